// ### qrfs_pkg.sv
/*
 * Shared constants of the flyback supervisor: timing figures, derived
 * cycle counts and state type.
 * Assumes a 40 MHz system clock.
 */
package qrfs_pkg;
	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40000000;

	// ------------------------------------------------------------
	// Timing figures in their own units
	// ------------------------------------------------------------
	localparam int MAINS_LOSS_MS   = 100;
	localparam int REM_DISCH_MS    = 100;
	localparam int SOFTSTART_MS    = 4;
	localparam int FAULT_BLANK_NS  = 27500;
	localparam int STEADY_TOUT_US  = 6;
	localparam int SS_TOUT_US      = 100;

	// ------------------------------------------------------------
	// Derived cycle counts (least times round up)
	// ------------------------------------------------------------
	localparam int MAINS_LOSS_CYC  = MAINS_LOSS_MS * (CLK_HZ / 1000);
	localparam int REM_DISCH_CYC   = REM_DISCH_MS * (CLK_HZ / 1000);
	localparam int SOFTSTART_CYC   = SOFTSTART_MS * (CLK_HZ / 1000);
	localparam int FAULT_BLANK_CYC = (FAULT_BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int STEADY_TOUT_CYC = STEADY_TOUT_US * (CLK_HZ / 1000000);
	localparam int SS_TOUT_CYC     = SS_TOUT_US * (CLK_HZ / 1000000);

	// ------------------------------------------------------------
	// Supervisor states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		QRFS_POWERUP,
		QRFS_SOFTSTART,
		QRFS_RUN,
		QRFS_OFF,
		QRFS_LATCHED
	} qrfs_state_t;
endpackage

// ### qrfs_supervisor.sv
/*
 * Supervisory and sequencing logic of a quasi-resonant flyback controller:
 * mains-loss discharge, remote off mode, fault latch, valley counting.
 * Assumes comparator outputs arrive asynchronously from analog sensing and
 * that the feedback path supplies the target valley number.
 */
// How it works
// - Mains loss acts only after 100 ms
// - Timer expiry closes discharge switch, enables HV
// - Mains monitor runs in off mode, startup
// - Remote-off high enters off mode, stops drive
// - Remote restart level low starts fresh startup
// - Start from power-up pulls remote-off low 100 ms
// - Fault above upper threshold latches off
// - Fault below lower threshold latches off
// - Overtemperature pull-up enabled at supply start
// - Lower fault ignored during soft-start
// - Fault valid after 27.5 us blanking
// - Latched: drive stops, supply held at bias
// - Latch cleared only by brown-out or discharge
// - No off mode while latched
// - Demag below threshold registers a valley
// - Timeout restarts on demag, substitutes valley
// - Timeout 6 us steady, 100 us soft-start
// - Each missed valley costs one timeout
// - 4 ms soft-start on every startup
`timescale 1ns/10ps
module qrfs_supervisor #(
	parameter int MAINS_LOSS_CYC = qrfs_pkg::MAINS_LOSS_CYC,
	parameter int REM_DISCH_CYC  = qrfs_pkg::REM_DISCH_CYC,
	parameter int SOFTSTART_CYC  = qrfs_pkg::SOFTSTART_CYC,
	parameter int VAL_W          = 3
) (
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic             mains_absent_i,
	input  wire logic             remote_off_above_i,
	input  wire logic             remote_restart_below_i,
	input  wire logic             fault_upper_i,
	input  wire logic             fault_lower_i,
	input  wire logic             demag_below_i,
	input  wire logic             supply_start_i,
	input  wire logic             line_undervoltage_fault_i,
	input  wire logic [VAL_W-1:0] target_valley_i,
	output logic                  gate_pulse_o,
	output logic                  discharge_switch_o,
	output logic                  hv_source_en_o,
	output logic                  remote_pulldown_o,
	output logic                  otp_pullup_en_o,
	output logic                  latched_bias_o,
	output logic                  off_mode_o,
	output logic                  softstart_o
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Bit map of the shared synchroniser bank:
	//   0 mains absent
	//   1 remote pin below restart level
	//   2 fault pin above upper threshold
	//   3 fault pin below lower threshold
	//   4 demag comparator below threshold
	//   5 supply at start threshold
	//   6 line undervoltage fault
	// Remote off level has its own pair further down
	// Every comparator adds two cycles of latency before any timer sees it
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] meta_r;
	logic [NSYNC-1:0] sync_r;
	assign raw_w = {line_undervoltage_fault_i, supply_start_i, demag_below_i, fault_lower_i,
		fault_upper_i, remote_restart_below_i, mains_absent_i};

	// Two flops per comparator; only the second is read
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= raw_w[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	logic rem_off_meta_r;
	logic rem_off_r;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rem_off_meta_r <= 1'b0;
			rem_off_r      <= 1'b0;
		end else begin
			rem_off_meta_r <= remote_off_above_i;
			rem_off_r      <= rem_off_meta_r;
		end
	end

	logic mains_abs_s;
	logic rem_on_s;
	logic f_up_s;
	logic f_lo_s;
	logic demag_s;
	logic vcc_on_s;
	logic bo_s;
	assign mains_abs_s = sync_r[0];
	assign rem_on_s    = sync_r[1];
	assign f_up_s      = sync_r[2];
	assign f_lo_s      = sync_r[3];
	assign demag_s     = sync_r[4];
	assign vcc_on_s    = sync_r[5];
	assign bo_s        = sync_r[6];

	// ------------------------------------------------------------
	// Mains-loss timer, independent of the supervisor state
	// ------------------------------------------------------------
	// Count saturates at the limit; discharge holds while mains stays absent
	// Limitation: a single synced high sample of mains presence restarts the
	// whole window, so a noisy sense network lengthens the timeout
	// Discharge drops as soon as mains returns, no minimum on-time
	logic [31:0] mains_cnt_r;
	logic        discharge_r;
	// Runs in every state so unplugging during off or startup drains caps
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mains_cnt_r <= 32'h0000_0000;
			discharge_r <= 1'b0;
		end else if (!mains_abs_s) begin
			mains_cnt_r <= 32'h0000_0000; // short dropouts reset the count
			discharge_r <= 1'b0;
		end else if (mains_cnt_r >= 32'(MAINS_LOSS_CYC - 1)) begin
			discharge_r <= 1'b1;
		end else begin
			mains_cnt_r <= mains_cnt_r + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// Fault blanking
	// ------------------------------------------------------------
	// Each comparator has its own window so one cannot shorten the other
	// A fault is valid once its counter reaches the blanking count
	// Trade-off: continuous level required, so chattering faults never latch
	localparam int BLK_W = $clog2(qrfs_pkg::FAULT_BLANK_CYC + 1);
	logic [BLK_W-1:0] up_cnt_r;
	logic [BLK_W-1:0] lo_cnt_r;
	logic             up_valid_w;
	logic             lo_valid_w;
	qrfs_pkg::qrfs_state_t state_r;
	logic             lo_armed_w;

	// Lower comparator only counts once soft-start has finished
	assign lo_armed_w = f_lo_s && (state_r == qrfs_pkg::QRFS_RUN);
	assign up_valid_w = (up_cnt_r == BLK_W'(qrfs_pkg::FAULT_BLANK_CYC));
	assign lo_valid_w = (lo_cnt_r == BLK_W'(qrfs_pkg::FAULT_BLANK_CYC));

	// Any gap in the comparator level restarts the blanking window
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			up_cnt_r <= '0;
			lo_cnt_r <= '0;
		end else begin
			if (!f_up_s)
				up_cnt_r <= '0;
			else if (!up_valid_w)
				up_cnt_r <= up_cnt_r + BLK_W'(1);
			if (!lo_armed_w)
				lo_cnt_r <= '0;
			else if (!lo_valid_w)
				lo_cnt_r <= lo_cnt_r + BLK_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Supervisor state machine
	// ------------------------------------------------------------
	logic [31:0] ss_cnt_r;
	logic [31:0] rem_cnt_r;
	logic        rem_pull_r;
	logic        start_w;
	logic        self_relax_w;
	qrfs_pkg::qrfs_state_t state_nxt;

	// Priority inside the switching states:
	//   latch first, so a fault always wins over a remote-off request
	//   then remote off, masked while our own pulldown holds the pin low
	//   then brown-out, back to power-up; a remote pulldown in progress keeps running
	//   then end of soft-start
	// Off mode restart is self-relaxing and skips the remote pulldown
	always_comb begin
		state_nxt    = state_r;
		start_w      = 1'b0;
		self_relax_w = 1'b0;
		case (state_r)
			qrfs_pkg::QRFS_POWERUP: begin
				if (vcc_on_s && !bo_s) begin
					state_nxt = qrfs_pkg::QRFS_SOFTSTART;
					start_w   = 1'b1;
				end
			end
			qrfs_pkg::QRFS_SOFTSTART,
			qrfs_pkg::QRFS_RUN: begin
				if (up_valid_w || lo_valid_w) begin
					state_nxt = qrfs_pkg::QRFS_LATCHED;
				end else if (rem_off_r && !rem_pull_r) begin
					state_nxt = qrfs_pkg::QRFS_OFF;
				end else if (bo_s) begin
					state_nxt = qrfs_pkg::QRFS_POWERUP;
				end else if (state_r == qrfs_pkg::QRFS_SOFTSTART &&
					ss_cnt_r >= 32'(SOFTSTART_CYC - 1)) begin
					state_nxt = qrfs_pkg::QRFS_RUN;
				end
			end
			qrfs_pkg::QRFS_OFF: begin
				if (rem_on_s) begin
					state_nxt    = qrfs_pkg::QRFS_SOFTSTART;
					start_w      = 1'b1;
					self_relax_w = 1'b1;
				end
			end
			qrfs_pkg::QRFS_LATCHED: begin
				// Off-mode request is ignored here
				if (bo_s || discharge_r)
					state_nxt = qrfs_pkg::QRFS_POWERUP;
			end
			default: state_nxt = qrfs_pkg::QRFS_POWERUP;
		endcase
	end

	// State register and soft-start timer
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r  <= qrfs_pkg::QRFS_POWERUP;
			ss_cnt_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			if (start_w)
				ss_cnt_r <= 32'h0000_0000;
			else if (state_r == qrfs_pkg::QRFS_SOFTSTART)
				ss_cnt_r <= ss_cnt_r + 32'h0000_0001;
		end
	end

	// Remote pin discharge pulse on every non-self-relaxing restart
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rem_pull_r <= 1'b0;
			rem_cnt_r  <= 32'h0000_0000;
		end else if (start_w && !self_relax_w) begin
			rem_pull_r <= 1'b1;
			rem_cnt_r  <= 32'h0000_0000;
		end else if (rem_pull_r) begin
			if (rem_cnt_r >= 32'(REM_DISCH_CYC - 1))
				rem_pull_r <= 1'b0;
			else
				rem_cnt_r <= rem_cnt_r + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// Valley detection and timeout substitution
	// ------------------------------------------------------------
	// Counter width fits the longer soft-start timeout
	// Both valleys and timeouts advance the same valley counter
	// Hazard: the limit shrinks at soft-start end, so the first run-mode
	// compare may expire at once; one early step is accepted
	localparam int TO_W = $clog2(qrfs_pkg::SS_TOUT_CYC + 1);
	logic             demag_d_r;
	logic             valley_w;
	logic [TO_W-1:0]  to_cnt_r;
	logic [TO_W-1:0]  to_lim_w;
	logic             to_exp_w;
	logic [VAL_W-1:0] valley_cnt_r;
	logic             switching_w;
	logic             step_w;

	assign switching_w = (state_r == qrfs_pkg::QRFS_SOFTSTART) || (state_r == qrfs_pkg::QRFS_RUN);
	assign valley_w    = demag_s && !demag_d_r; // falling below threshold
	// Long timeout during soft-start avoids continuous conduction
	assign to_lim_w    = (state_r == qrfs_pkg::QRFS_SOFTSTART) ?
		TO_W'(qrfs_pkg::SS_TOUT_CYC) : TO_W'(qrfs_pkg::STEADY_TOUT_CYC);
	assign to_exp_w    = (to_cnt_r >= to_lim_w - TO_W'(1));
	assign step_w      = valley_w || to_exp_w;

	// Timeout restarts on each detected valley or its own expiry
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			demag_d_r <= 1'b0;
			to_cnt_r  <= '0;
		end else begin
			demag_d_r <= demag_s;
			if (!switching_w || step_w)
				to_cnt_r <= '0;
			else
				to_cnt_r <= to_cnt_r + TO_W'(1);
		end
	end

	// Valley counter: switch on target, else count
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			valley_cnt_r <= '0;
			gate_pulse_o <= 1'b0;
		end else begin
			gate_pulse_o <= 1'b0;
			if (!switching_w || state_nxt == qrfs_pkg::QRFS_LATCHED) begin
				valley_cnt_r <= '0; // drive stops at once
			end else if (step_w) begin
				if (valley_cnt_r + VAL_W'(1) >= target_valley_i) begin
					gate_pulse_o <= 1'b1;
					valley_cnt_r <= '0;
				end else begin
					valley_cnt_r <= valley_cnt_r + VAL_W'(1);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registered status and analog controls
	// ------------------------------------------------------------
	// All outputs come from flops so analog switches never see glitches
	// Status follows the state register with one cycle of delay
	// HV source also runs during power-up to charge the supply capacitor
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			discharge_switch_o <= 1'b0;
			hv_source_en_o     <= 1'b0;
			remote_pulldown_o  <= 1'b0;
			otp_pullup_en_o    <= 1'b0;
			latched_bias_o     <= 1'b0;
			off_mode_o         <= 1'b0;
			softstart_o        <= 1'b0;
		end else begin
			discharge_switch_o <= discharge_r;
			hv_source_en_o     <= discharge_r || (state_r == qrfs_pkg::QRFS_POWERUP);
			remote_pulldown_o  <= rem_pull_r;
			otp_pullup_en_o    <= vcc_on_s;
			latched_bias_o     <= (state_r == qrfs_pkg::QRFS_LATCHED);
			off_mode_o         <= (state_r == qrfs_pkg::QRFS_OFF);
			softstart_o        <= (state_r == qrfs_pkg::QRFS_SOFTSTART);
		end
	end
endmodule

// ### qrfs_supervisor_props.sv
/* Port-timing checker of the flyback supervisor.
   Assumes binding into every qrfs_supervisor instance. */
`timescale 1ns/10ps
module qrfs_supervisor_props #(
	parameter int MAINS_LOSS_CYC = 50,
	parameter int REM_DISCH_CYC  = 40
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic mains_absent_i,
	input wire logic supply_start_i,
	input wire logic fault_upper_i,
	input wire logic fault_lower_i,
	input wire logic line_undervoltage_fault_i,
	input wire logic gate_pulse_o,
	input wire logic discharge_switch_o,
	input wire logic hv_source_en_o,
	input wire logic remote_pulldown_o,
	input wire logic otp_pullup_en_o,
	input wire logic latched_bias_o,
	input wire logic off_mode_o
);
	localparam int FB_CYC = qrfs_pkg::FAULT_BLANK_CYC;
	int m_cnt_r;
	int f_cnt_r;
	int b_cnt_r;
	int p_cnt_r;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	// ----------------
	// Run lengths
	// ----------------
	// Raw causes lead the synced view by two flops, so counts err high
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			m_cnt_r <= 0;
			f_cnt_r <= 0;
			b_cnt_r <= 0;
			p_cnt_r <= 0;
		end else begin
			m_cnt_r <= mains_absent_i ? m_cnt_r + 1 : 0;
			f_cnt_r <= (fault_upper_i || fault_lower_i) ? f_cnt_r + 1 : 0;
			b_cnt_r <= line_undervoltage_fault_i ? 0 : b_cnt_r + 1;
			p_cnt_r <= remote_pulldown_o ? p_cnt_r + 1 : 0;
		end
	end
	// ----------------
	// Properties
	// ----------------
	sequence s_pd_end; $fell(remote_pulldown_o); endsequence
	sequence s_latch_in; $rose(latched_bias_o); endsequence
	property p_mains; $rose(discharge_switch_o) |-> m_cnt_r >= MAINS_LOSS_CYC; endproperty
	property p_disch; discharge_switch_o |-> hv_source_en_o; endproperty
	property p_off; off_mode_o |-> !gate_pulse_o; endproperty
	property p_latch; latched_bias_o |-> !gate_pulse_o && !off_mode_o; endproperty
	property p_otp; (!supply_start_i)[*4] |-> !otp_pullup_en_o; endproperty
	property p_blank; s_latch_in |-> f_cnt_r >= FB_CYC; endproperty
	property p_pd; s_pd_end |-> p_cnt_r == REM_DISCH_CYC; endproperty
	property p_hold; latched_bias_o && m_cnt_r < MAINS_LOSS_CYC && b_cnt_r > 4 |=> latched_bias_o; endproperty
	a_mains: assert property (p_mains) else $error("discharge before mains timeout");
	a_disch: assert property (p_disch) else $error("discharge without HV source");
	a_off: assert property (p_off) else $error("gate pulse in off mode");
	a_latch: assert property (p_latch) else $error("pulse or off while latched");
	a_otp: assert property (p_otp) else $error("pull-up on before supply start");
	a_blank: assert property (p_blank) else $error("fault latched before blanking");
	a_pd: assert property (p_pd) else $error("remote pulldown length wrong");
	a_hold: assert property (p_hold) else $error("latch cleared without cause");
endmodule
bind qrfs_supervisor qrfs_supervisor_props #(
	.MAINS_LOSS_CYC(MAINS_LOSS_CYC),
	.REM_DISCH_CYC (REM_DISCH_CYC)
) u_props (.*);

// ### qrfs_remote_model.sv
/* Remote pin network with secondary-side optocoupler.
   Assumes it is clocked with the supervisor. */
`timescale 1ns/10ps
module qrfs_remote_model (
	input  wire logic clock_i,
	input  wire logic opto_release_i,
	input  wire logic pulldown_i,
	input  wire logic off_mode_i,
	output logic      remote_off_above_o,
	output logic      remote_restart_below_o
);
	logic [7:0] level_r = 8'h00;
	// Pin charges only while the opto lets go; droops once Vcc dies in off mode
	always_ff @(posedge clock_i) begin
		if (!opto_release_i || pulldown_i)
			level_r <= 8'h00;
		else if (off_mode_i)
			level_r <= (level_r == 8'h00) ? 8'h00 : level_r - 8'h01;
		else if (level_r != 8'hFF)
			level_r <= level_r + 8'h01;
	end
	// Off level and restart level as comparator outputs
	assign remote_off_above_o = level_r >= 8'h50;
	assign remote_restart_below_o = level_r <= 8'h0F;
endmodule

// ### qrfs_supervisor_test.sv
/* Self-checking bench of the flyback supervisor.
   Assumes short counts for mains, pulldown and soft-start. */
`timescale 1ns/10ps
module qrfs_supervisor_test;
	localparam int ML = 50;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic mains_absent_i = 1'b0;
	logic fault_upper_i = 1'b0;
	logic fault_lower_i = 1'b0;
	logic demag_below_i = 1'b0;
	logic supply_start_i = 1'b0;
	logic line_undervoltage_fault_i = 1'b0;
	logic opto_release = 1'b0;
	logic [2:0] target_valley_i = 3'h1;
	logic remote_off_above_i, remote_restart_below_i, gate_pulse_o, discharge_switch_o;
	logic hv_source_en_o, remote_pulldown_o, otp_pullup_en_o, latched_bias_o, off_mode_o, softstart_o;
	int num_errors = 0;
	int checks_done = 0;
	int n;
	always #12.5 clock_i = ~clock_i;
	qrfs_supervisor #(.MAINS_LOSS_CYC(ML), .REM_DISCH_CYC(40), .SOFTSTART_CYC(9000)) u_dut (.*);
	qrfs_remote_model u_remote (.clock_i(clock_i), .opto_release_i(opto_release), .pulldown_i(remote_pulldown_o),
		.off_mode_i(off_mode_o), .remote_off_above_o(remote_off_above_i), .remote_restart_below_o(remote_restart_below_i));
	task automatic step(int k); repeat (k) @(posedge clock_i); endtask
	task automatic settle; @(negedge clock_i); endtask
	task automatic chk(string s, int e, logic [31:0] g, int t = 0);
		checks_done++;
		if ($isunknown(g) || g + t < e || g > e + t) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", s, e, g);
		end
	endtask
	// Cycles up to the next gate pulse
	task automatic gap(output int c);
		c = 0;
		do begin @(negedge clock_i); c++; end while (gate_pulse_o !== 1'b1 && c < 9000);
	endtask
	task automatic finish_test;
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_start;
		settle; chk("hv_rst", 0, hv_source_en_o);
		step(2); arst_n_i <= 1'b1;
		step(2); settle; chk("hv_pwrup", 1, hv_source_en_o);
		step(1); supply_start_i <= 1'b1; fault_lower_i <= 1'b1;
		step(8); settle; chk("pulldown", 1, remote_pulldown_o);
		chk("otp_en", 1, otp_pullup_en_o);
		step(1200); fault_lower_i <= 1'b0;
		settle; chk("ot_in_ss", 0, latched_bias_o);
		gap(n); gap(n); chk("ss_tout", 4000, n, 2);
		n = 0;
		while (softstart_o === 1'b1 && n < 2000) begin @(negedge clock_i); n++; end
		chk("ss_len", 1000, n, 8);
	endtask
	task automatic t_valley;
		gap(n); gap(n); chk("run_tout", 240, n, 2);
		step(1); target_valley_i <= 3'h3;
		gap(n); gap(n); chk("missed", 720, n, 3);
		step(1); target_valley_i <= 3'h1;
		gap(n); step(20); demag_below_i <= 1'b1;
		gap(n); chk("valley", 4, n, 1);
		step(1); demag_below_i <= 1'b0;
	endtask
	task automatic t_fault;
		step(1); fault_upper_i <= 1'b1; step(500); fault_upper_i <= 1'b0;
		step(20); settle; chk("short_flt", 0, latched_bias_o);
		step(1); fault_lower_i <= 1'b1; step(1120); settle; chk("ot_latch", 1, latched_bias_o);
		step(1); fault_lower_i <= 1'b0; opto_release <= 1'b1;
		step(150); settle; chk("off_latched", 0, off_mode_o);
		step(1); opto_release <= 1'b0; step(60); settle; chk("hold", 1, latched_bias_o);
		step(1); line_undervoltage_fault_i <= 1'b1; step(10); line_undervoltage_fault_i <= 1'b0;
		settle; chk("bo_clear", 0, latched_bias_o);
		step(60); fault_upper_i <= 1'b1; step(1120); settle; chk("ov_latch", 1, latched_bias_o);
		step(1); fault_upper_i <= 1'b0; mains_absent_i <= 1'b1; step(30); mains_absent_i <= 1'b0;
		step(10); settle; chk("dropout", 0, discharge_switch_o);
		step(1); mains_absent_i <= 1'b1; step(ML + 8); settle; chk("disch", 1, discharge_switch_o);
		chk("hv_disch", 1, hv_source_en_o);
		chk("mains_clr", 0, latched_bias_o);
		step(1); mains_absent_i <= 1'b0;
	endtask
	task automatic t_remote;
		step(60); opto_release <= 1'b1; step(100); settle; chk("off", 1, off_mode_o);
		n = 0;
		while (off_mode_o === 1'b1 && n < 300) begin @(negedge clock_i); n++; end
		chk("restart", 1, softstart_o);
		chk("relax_pd", 0, remote_pulldown_o);
		step(80); mains_absent_i <= 1'b1; step(ML + 8); settle; chk("off_disch", 1, discharge_switch_o);
	endtask
	initial begin
		t_start();
		t_valley();
		t_fault();
		t_remote();
		finish_test();
	end
	// Watchdog well beyond the planned run length
	initial begin
		step(40000);
		num_errors++;
		finish_test();
	end
endmodule
